//--- hdl/usp_pkg.sv
// constants for the serial pin unit: register map, reset values, counts
// assumes a 32-bit apb bus and a single 25 MHz system clock
package usp_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_DIV     = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_TXDATA  = 8'h0C;
  localparam logic [7:0]  OFS_RXDATA  = 8'h10;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int          CTRL_TX_EN  = 0;
  localparam int          CTRL_RX_EN  = 1;
  localparam int          CTRL_LOOP   = 2;
  localparam int          CTRL_RTS_AUTO = 3;
  localparam int          CTRL_RTS_ON = 4;
  localparam int          CTRL_STOP   = 5;
  localparam int          CTRL_W      = 5;
  // ----------------------------------------
  // reset values and sizes
  // ----------------------------------------
  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [15:0] DIV_RST     = 16'h000D;
  localparam int          DATA_W      = 8;
  localparam int          QDEPTH      = 4;
  localparam logic [2:0]  QCNT_RST    = 3'h0;
  localparam logic [2:0]  RTS_LEVEL   = 3'h3;
  localparam logic [2:0]  BITS_LAST   = 3'h7;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } usp_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } usp_rx_e;
endpackage

//--- hdl/usp_uart.sv
// serial pin unit: apb registers, transmitter, receiver, receive queue, handshake
// assumes pins arrive asynchronously and apb runs on I_CLK
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module usp_uart
  import usp_pkg::*;
(
  input  wire logic        I_CLK,      // system clock
  input  wire logic        I_RSTN,     // async reset, low
  input  wire logic        I_CE,       // clock enable
  input  wire logic        PSEL,       // apb select
  input  wire logic        PENABLE,    // apb enable
  input  wire logic        PWRITE,     // apb direction
  input  wire logic [7:0]  PADDR,      // apb byte address
  input  wire logic [31:0] PWDATA,     // apb write data
  output logic      [31:0] PRDATA,     // apb read data
  output logic             PREADY,     // apb ready
  output logic             PSLVERR,    // apb error, unmapped
  input  wire logic        I_RXD,      // serial_rx_in pin
  input  wire logic        I_CTS_N,    // clear_to_send_in pin, low
  output logic             O_TXD,      // serial_tx_out pin
  output logic             O_RTS_N,    // request_to_send_out pin, low
  output logic             O_CLK_ON    // unit clock running
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic rx_meta, rx_sync, rx_prev, cts_meta, cts_n_sync;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_meta    <= 1'b1;
      rx_sync    <= 1'b1;
      rx_prev    <= 1'b1;
      cts_meta   <= 1'b1;
      cts_n_sync <= 1'b1;
    end else if (I_CE) begin
      rx_meta    <= I_RXD;
      rx_sync    <= rx_meta;
      rx_prev    <= rx_sync;
      cts_meta   <= I_CTS_N;
      cts_n_sync <= cts_meta;
    end
  end
  // ----------------------------------------
  // registers and apb slave
  // ----------------------------------------
  logic [CTRL_W-1:0]  ctrl;
  logic [15:0]        div;
  logic               stopped;
  logic [DATA_W-1:0]  tx_hold;
  logic               hold_full;
  logic [DATA_W-1:0]  queue [QDEPTH];
  logic [1:0]         q_rd, q_wr;
  logic [2:0]         q_cnt;
  logic               q_push;
  logic [DATA_W-1:0]  rx_shift;
  logic               tx_take;
  logic               tx_busy;
  logic               rx_overrun;
  logic               access, wr_acc, rd_acc, hit;
  logic               run;
  logic               rx_line;

  assign access = PSEL && PENABLE && PREADY;
  assign wr_acc = access && PWRITE;
  assign rd_acc = access && !PWRITE;
  assign hit    = (PADDR == OFS_CTRL) || (PADDR == OFS_DIV) || (PADDR == OFS_STATUS) ||
                  (PADDR == OFS_TXDATA) || (PADDR == OFS_RXDATA);
  assign run    = I_CE && !stopped;
  // no wait state: ready in the first access cycle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (I_CE) begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      if (PSEL && !PENABLE && !PWRITE) begin
        unique case (PADDR)
          OFS_CTRL:   PRDATA <= {27'h0, ctrl};
          OFS_DIV:    PRDATA <= {16'h0, div};
          OFS_STATUS: PRDATA <= {24'h0, rx_overrun, stopped, q_cnt, tx_busy, hold_full,
                                 (q_cnt != QCNT_RST)};
          OFS_RXDATA: PRDATA <= {24'h0, queue[q_rd]};
          default:    PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl <= CTRL_RST;
      div  <= DIV_RST;
    end else if (I_CE && wr_acc) begin
      if (PADDR == OFS_CTRL) ctrl <= PWDATA[CTRL_W-1:0];
      if (PADDR == OFS_DIV) div <= (PWDATA[15:0] == 16'h0000) ? 16'h0001 : PWDATA[15:0];
    end
  end
  // rx edge restarts the stopped clock
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      stopped <= 1'b0;
    end else if (I_CE) begin
      if (rx_sync != rx_prev) stopped <= 1'b0;
      else if (wr_acc && PADDR == OFS_CTRL && PWDATA[CTRL_STOP]) stopped <= 1'b1;
    end
  end
  // writes while the holding slot is full are dropped
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_hold   <= 8'h00;
      hold_full <= 1'b0;
    end else if (I_CE) begin
      if (wr_acc && PADDR == OFS_TXDATA && !hold_full) begin
        tx_hold   <= PWDATA[DATA_W-1:0];
        hold_full <= 1'b1;
      end else if (tx_take && run) begin
        hold_full <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // receive queue
  // ----------------------------------------
  logic pop;
  assign pop = rd_acc && (PADDR == OFS_RXDATA) && (q_cnt != QCNT_RST);
  always_ff @(posedge I_CLK) begin
    if (I_CE && q_push && q_cnt != 3'(QDEPTH)) queue[q_wr] <= rx_shift;
  end
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      q_rd       <= 2'h0;
      q_wr       <= 2'h0;
      q_cnt      <= QCNT_RST;
      rx_overrun <= 1'b0;
    end else if (I_CE) begin
      if (pop) q_rd <= q_rd + 2'h1;
      // full queue: new character is lost and flagged
      if (q_push && q_cnt == 3'(QDEPTH)) rx_overrun <= 1'b1;
      else if (wr_acc && PADDR == OFS_STATUS && PWDATA[7]) rx_overrun <= 1'b0;
      if (q_push && q_cnt != 3'(QDEPTH)) begin
        q_wr <= q_wr + 2'h1;
        if (!pop) q_cnt <= q_cnt + 3'h1;
      end else if (pop) begin
        q_cnt <= q_cnt - 3'h1;
      end
    end
  end
  // ----------------------------------------
  // serial clock: toggles every div cycles
  // ----------------------------------------
  logic [15:0] baud_cnt;
  logic        sclk, sclk_fall;
  // compare with >=: a divisor shrunk below the count would else stall for 64k cycles
  assign sclk_fall = sclk && (baud_cnt >= div - 16'h0001);
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      baud_cnt <= 16'h0000;
      sclk     <= 1'b0;
    end else if (run) begin
      if (baud_cnt >= div - 16'h0001) begin
        baud_cnt <= 16'h0000;
        sclk     <= !sclk;
      end else begin
        baud_cnt <= baud_cnt + 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  usp_tx_e           tx_st;
  logic [DATA_W-1:0] tx_shift;
  logic [2:0]        tx_bit;
  logic              tx_line;
  assign tx_busy = (tx_st != TX_IDLE);
  assign tx_take = sclk_fall && (tx_st == TX_IDLE) && hold_full && ctrl[CTRL_TX_EN] &&
                   !cts_n_sync;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_st    <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_bit   <= 3'h0;
      tx_line  <= 1'b1;
    end else if (run && sclk_fall) begin
      unique case (tx_st)
        TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_take) begin
            tx_shift <= tx_hold;
            tx_line  <= 1'b0;  // start bit low
            tx_st    <= TX_START;
          end
        end
        TX_START: begin
          tx_line  <= tx_shift[0];
          tx_shift <= tx_shift >> 1;
          tx_bit   <= 3'h0;
          tx_st    <= TX_DATA;
        end
        TX_DATA: begin
          if (tx_bit == BITS_LAST) begin
            tx_line <= 1'b1;  // stop bit high
            tx_st   <= TX_STOP;
          end else begin
            tx_line  <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_bit   <= tx_bit + 3'h1;
          end
        end
        TX_STOP: begin
          tx_line <= 1'b1;
          tx_st   <= TX_IDLE;
        end
      endcase
    end
  end
  // pin held at mark when off or looped back
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) O_TXD <= 1'b1;
    else if (I_CE) O_TXD <= ctrl[CTRL_LOOP] || !ctrl[CTRL_TX_EN] || !tx_busy || tx_line;
  end
  // ----------------------------------------
  // receiver: samples mid-bit, bit time 2*div
  // ----------------------------------------
  usp_rx_e    rx_st;
  logic [16:0] rx_cnt;
  logic [2:0]  rx_bit;
  assign rx_line = ctrl[CTRL_LOOP] ? tx_line : rx_sync;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_st    <= RX_IDLE;
      rx_cnt   <= 17'h00000;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      q_push   <= 1'b0;
    end else if (run) begin
      q_push <= 1'b0;
      rx_cnt <= rx_cnt + 17'h00001;
      unique case (rx_st)
        RX_IDLE: begin
          rx_cnt <= 17'h00001;
          // low level marks a start bit
          if (ctrl[CTRL_RX_EN] && !rx_line) rx_st <= RX_START;
        end
        RX_START: begin
          if (rx_cnt == {1'b0, div}) begin
            rx_cnt <= 17'h00001;
            rx_bit <= 3'h0;
            // glitch shorter than half a bit is ignored
            rx_st  <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cnt == {div, 1'b0}) begin
            rx_cnt   <= 17'h00001;
            rx_shift <= {rx_line, rx_shift[DATA_W-1:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == BITS_LAST) rx_st <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_cnt == {div, 1'b0}) begin
            // character kept only with a high stop bit
            q_push <= rx_line;
            rx_st  <= RX_IDLE;
          end
        end
      endcase
    end else if (I_CE) begin
      q_push <= 1'b0;
    end
  end
  // ----------------------------------------
  // handshake and clock status outputs
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RTS_N  <= 1'b1;
      O_CLK_ON <= 1'b1;
    end else if (I_CE) begin
      // auto mode negates at the queue level
      if (ctrl[CTRL_RTS_AUTO]) O_RTS_N <= (q_cnt >= RTS_LEVEL);
      else O_RTS_N <= !ctrl[CTRL_RTS_ON];
      O_CLK_ON <= !stopped;
    end
  end
endmodule

//--- bench/usp_monitor.sv
// port checker for the serial pin unit
// assumes divisor at most 4, so 100 high cycles on the tx pin is an idle line
`timescale 1ns/1ps
module usp_monitor (
  input wire logic I_CLK,    // clock
  input wire logic I_RSTN,   // reset, low
  input wire logic I_CE,     // clock enable
  input wire logic PSEL,     // apb select
  input wire logic PENABLE,  // apb enable
  input wire logic PREADY,   // apb ready
  input wire logic PSLVERR,  // apb error
  input wire logic I_RXD,    // rx pin
  input wire logic I_CTS_N,  // cts pin
  input wire logic O_TXD,    // tx pin
  input wire logic O_RTS_N,  // rts pin
  input wire logic O_CLK_ON  // unit clock on
);
  logic [7:0] hi_cnt;
  logic [3:0] cts_cnt;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // saturating run lengths
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hi_cnt  <= 8'h00;
      cts_cnt <= 4'h0;
    end else begin
      hi_cnt  <= !O_TXD ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
      cts_cnt <= !I_CTS_N ? 4'h0 : cts_cnt + {3'h0, cts_cnt != 4'hF};
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reset_tx_mark: assert property ($rose(I_RSTN) |-> O_TXD && O_CLK_ON)
    else $error("tx pin not at mark after reset");
  a_reset_rts_off: assert property ($rose(I_RSTN) |-> O_RTS_N)
    else $error("rts asserted after reset");
  a_cts_holds_start: assert property (hi_cnt >= 8'h64 && cts_cnt >= 4'h8 |=> O_TXD)
    else $error("character started without clear to send");
  a_bit_min_width: assert property ($changed(O_TXD) |=> $stable(O_TXD))
    else $error("tx level shorter than two cycles");
  // a frozen unit cannot see the edge, so only edges under enable count
  a_rx_edge_wakes: assert property (I_CE && !O_CLK_ON && $changed(I_RXD)
    |-> ##[1:6] O_CLK_ON)
    else $error("rx edge did not restart clock");
  a_ready_after_setup: assert property (PSEL && !PENABLE && I_CE |=> PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY && I_CE |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  cover property ($fell(O_TXD));
  cover property (!O_CLK_ON);
  cover property (PSLVERR);
  cover property ($rose(O_RTS_N));
endmodule

bind usp_uart usp_monitor usp_monitor_i (.I_CLK, .I_RSTN, .I_CE, .PSEL, .PENABLE, .PREADY,
  .PSLVERR, .I_RXD, .I_CTS_N, .O_TXD, .O_RTS_N, .O_CLK_ON);

//--- bench/usp_remote.sv
// remote serial partner: frames onto the rx pin, decodes the tx pin
// assumes one bit lasts BIT system clock cycles
`timescale 1ns/1ps
module usp_remote #(
  parameter int BIT = 8
) (
  input  wire logic i_clk,   // system clock
  input  wire logic i_txd,   // device tx pin
  input  wire logic i_rts_n, // device rts pin
  output logic      o_rxd,   // device rx pin
  output logic      o_cts_n  // device cts pin
);
  initial begin
    o_rxd   = 1'b1;
    o_cts_n = 1'b1;
  end
  task set_cts(input logic v);
    @(posedge i_clk);
    o_cts_n <= v;
  endtask
  // short low pulse, below half a bit so no start is taken
  task glitch;
    @(posedge i_clk);
    o_rxd <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask
  // lsb first framing, started once rts asserted or after 4000 cycles
  task send(input logic [7:0] b);
    int k;
    k = 0;
    while (i_rts_n !== 1'b0 && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT - 1) @(posedge i_clk);
    end
  endtask
  // mid-bit sampling, lsb first, start low and stop high
  task recv(output logic [7:0] b, output logic ok);
    int k;
    k = 0;
    b = 8'h00;
    while (i_txd !== 1'b0 && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    repeat (BIT / 2) @(posedge i_clk);
    ok = (i_txd === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      b[i] = i_txd;
    end
    repeat (BIT) @(posedge i_clk);
    ok = ok && (i_txd === 1'b1);
  endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for the serial pin unit
// assumes the remote partner model and the bound port checker
`timescale 1ns/1ps
module testbench
  import usp_pkg::*;
  ();
  logic        I_CLK, I_RSTN, I_CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        I_RXD, I_CTS_N, O_TXD, O_RTS_N, O_CLK_ON, e, ok;
  logic [7:0]  PADDR, b;
  logic [31:0] PWDATA, PRDATA, q;
  int          n_fail, n_tests;
  usp_uart usp_uart_i (.I_CLK, .I_RSTN, .I_CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .I_RXD, .I_CTS_N, .O_TXD, .O_RTS_N, .O_CLK_ON);
  usp_remote #(.BIT(8)) usp_remote_i (.i_clk(I_CLK), .i_txd(O_TXD), .i_rts_n(O_RTS_N),
    .o_rxd(I_RXD), .o_cts_n(I_CTS_N));
  initial begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end
  task end_sim;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer; waits for ready, never a fixed count
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge I_CLK);
    PSEL    <= 1'b1;
    PADDR   <= a;
    PWRITE  <= w;
    PWDATA  <= d;
    @(posedge I_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge I_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (PREADY !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t apb transfer got no ready", $time);
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  task hold_hi(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge I_CLK);
      if (O_TXD !== 1'b1) bad++;
    end
    chk(32'(bad), 32'h0);
  endtask
  task rx_pop(input logic [7:0] x);
    int k;
    k = 0;
    q = 32'h0;
    while (q[0] !== 1'b1 && k < 300) begin
      rd(OFS_STATUS);
      k++;
    end
    if (q[0] !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t receive queue stayed empty", $time);
    end
    rd(OFS_RXDATA);
    chk(q, {24'h0, x});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    chk({29'h0, O_TXD, O_RTS_N, O_CLK_ON}, 32'h7);
    rd(OFS_CTRL);
    chk(q, 32'h0);
    rd(OFS_DIV);
    chk(q, {16'h0, DIV_RST});
    wr(OFS_DIV, 32'h0);
    rd(OFS_DIV);
    chk(q, 32'h1);
    rd(8'h14);
    chk({q[30:0], e}, 32'h1);
  endtask
  task t_tx;
    wr(OFS_DIV, 32'h4);
    wr(OFS_TXDATA, 32'hA5);
    hold_hi(120);
    wr(OFS_CTRL, 32'h13);
    hold_hi(150);
    usp_remote_i.set_cts(1'b0);
    usp_remote_i.recv(b, ok);
    chk({23'h0, ok, b}, 32'h1A5);
    wr(OFS_TXDATA, 32'h3C);
    usp_remote_i.recv(b, ok);
    chk({23'h0, ok, b}, 32'h13C);
  endtask
  task t_rts;
    wr(OFS_CTRL, 32'h0B);
    usp_remote_i.send(8'h11);
    usp_remote_i.send(8'h22);
    usp_remote_i.send(8'h33);
    repeat (20) @(posedge I_CLK);
    chk(32'(O_RTS_N), 32'h1);
    rd(OFS_STATUS);
    chk(32'(q[5:3]), 32'h3);
    rx_pop(8'h11);
    repeat (3) @(posedge I_CLK);
    chk(32'(O_RTS_N), 32'h0);
    rx_pop(8'h22);
    rx_pop(8'h33);
  endtask
  // fifth character hits a full queue: lost and flagged, flag cleared by write
  task t_overrun;
    wr(OFS_CTRL, 32'h13);
    for (int i = 0; i < 5; i++) usp_remote_i.send(8'(8'h61 + i));
    repeat (20) @(posedge I_CLK);
    rd(OFS_STATUS);
    chk(32'(q[7:3]), 32'h14);
    wr(OFS_STATUS, 32'h80);
    rd(OFS_STATUS);
    chk(32'(q[7:3]), 32'h04);
    for (int i = 0; i < 4; i++) rx_pop(8'(8'h61 + i));
  endtask
  task t_loop;
    wr(OFS_CTRL, 32'h07);
    wr(OFS_TXDATA, 32'h5A);
    hold_hi(100);
    rx_pop(8'h5A);
  endtask
  task t_wake;
    wr(OFS_CTRL, 32'h22);
    repeat (4) @(posedge I_CLK);
    chk(32'(O_CLK_ON), 32'h0);
    I_CE <= 1'b0;
    usp_remote_i.glitch();
    repeat (8) @(posedge I_CLK);
    chk(32'(O_CLK_ON), 32'h0);
    I_CE <= 1'b1;
    usp_remote_i.glitch();
    repeat (8) @(posedge I_CLK);
    chk(32'(O_CLK_ON), 32'h1);
  endtask
  initial begin
    I_RSTN  = 1'b0;
    I_CE    = 1'b1;
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = 8'h00;
    PWDATA  = 32'h0;
    n_fail  = 0;
    n_tests = 0;
    repeat (8) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    t_reset;
    t_tx;
    usp_remote_i.send(8'hC3);
    rx_pop(8'hC3);
    t_rts;
    t_overrun;
    t_loop;
    t_wake;
    end_sim;
  end
  // hang guard, well beyond the few thousand cycles needed
  initial begin
    repeat (30000) @(posedge I_CLK);
    n_fail++;
    end_sim;
  end
endmodule
